// ---- cicif_core.sv ----
/*
 * Third-order comb interpolator in recursive form: comb differences at the
 * word rate, three integrators at the oversampled rate.
 * Assumes load and tick are one-cycle strobes from the device frame logic.
 */
`default_nettype none

module cicif_core
    import cicif_pkg::*;
#(
    parameter int unsigned W = LP_ACC_W
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clr,
    input wire logic load,
    input wire logic tick,
    input wire logic [1:0] rate,
    input wire logic [15:0] x_in,
    output logic [15:0] y_out
);

    if (W < LP_ACC_MIN_W) begin : g_bad_w
        $error("cicif_core: accumulator width too small");
    end

    function automatic logic signed [W-1:0] sext(input logic [15:0] v);
        sext = {{(W - 16){v[15]}}, v};
    endfunction

    logic [15:0] x1_q, x2_q, x3_q, x1_d, x2_d, x3_d;
    logic signed [W-1:0] i1_q, i2_q, i3_q, i1_d, i2_d, i3_d;
    logic signed [W-1:0] c3, inj, shifted;
    logic [2:0] k;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        k = {1'b0, rate} + 3'h1;
        c3 = sext(x_in) - ((sext(x1_q) <<< 1) + sext(x1_q))
            + ((sext(x2_q) <<< 1) + sext(x2_q)) - sext(x3_q);
        inj = load ? (c3 <<< k) : '0;
        x1_d = x1_q;
        x2_d = x2_q;
        x3_d = x3_q;
        i1_d = i1_q;
        i2_d = i2_q;
        i3_d = i3_q;
        if (clr) begin
            x1_d = LP_MID_SCALE;
            x2_d = LP_MID_SCALE;
            x3_d = LP_MID_SCALE;
            i1_d = '0;
            i2_d = '0;
            i3_d = '0;
        end else if (tick) begin
            i1_d = i1_q + inj;
            i2_d = i2_q + i1_q;
            i3_d = i3_q + i2_q;
            if (load) begin
                x1_d = x_in;
                x2_d = x1_q;
                x3_d = x2_q;
            end
        end
        // Divide by N cubed; wraparound is harmless
        shifted = i3_q >>> (3 * k);
        y_out = shifted[15:0];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            x1_q <= LP_MID_SCALE;
            x2_q <= LP_MID_SCALE;
            x3_q <= LP_MID_SCALE;
            i1_q <= '0;
            i2_q <= '0;
            i3_q <= '0;
        end else begin
            x1_q <= x1_d;
            x2_q <= x2_d;
            x3_q <= x3_d;
            i1_q <= i1_d;
            i2_q <= i2_d;
            i3_q <= i3_d;
        end
    end

endmodule // cicif_core

`default_nettype wire

// ---- cicif_dev.sv ----
/*
 * Device end: samples the serial word link, frames input words, runs the
 * comb interpolator and drives the converter latch word.
 * Assumes all link pins are asynchronous to clk and that the link clock
 * half period spans at least two clk cycles.
 */
// Our own choices: the Avalon-MM slave port and the register addresses.
//
// Contract
// - Three cascaded moving-sum combs, normalised
// - Output lags input by two frames
// - Repeated word yields that word out
// - Recursive form, valid with 16 clocks
// - Host keeps bit clock continuous
// - Any count only in release frame
// - Latch updates every 16/N bit clocks
// - One word per 16 bit clocks
// - Uses current and three previous words
// - History starts at mid-scale
// - Host keeps oversampled rate within limit
// - Bypass takes holding register directly
// - Filter runs on during bypass
// - Mute forces mid-scale after frame
// - Filter off gives raw words
// - Filter reset drives mid-scale
// - Rate codes give 2x to 16x
// - MSB first shift, frame latch
// - Wrong bit count triggers filter reset
// - Filter reset clears filter only
// - Two's complement, zero is mid-scale
`default_nettype none

module cicif_dev
    import cicif_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    cicif_link_if.dev link,
    output logic [15:0] dac_word,
    output logic dac_strobe,
    output logic frame_error
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [LP_PIN_N-1:0] pin_raw, pin_s1_q, pin_s2_q;
    logic sclk_prev_q;

    assign pin_raw[LP_PIN_SCLK] = link.sclk;
    assign pin_raw[LP_PIN_FS] = link.word_frame_sync;
    assign pin_raw[LP_PIN_SD] = link.serial_data_in;
    assign pin_raw[LP_PIN_BYP_N] = link.filter_bypass_n;
    assign pin_raw[LP_PIN_FRST_N] = link.filter_reset_n;
    assign pin_raw[LP_PIN_RATE_LO] = link.rate_select_lo;
    assign pin_raw[LP_PIN_RATE_HI] = link.rate_select_hi;
    assign pin_raw[LP_PIN_MUTE_N] = link.output_mute_n;

    // Control pins reset low, as they must be held at power up
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            sclk_prev_q <= 1'b0;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            sclk_prev_q <= pin_s2_q[LP_PIN_SCLK];
        end
    end

    logic sclk_rise, fs_s, sd_s, byp_n, frst_n, mute_n;
    logic [1:0] rate_pins;

    assign sclk_rise = pin_s2_q[LP_PIN_SCLK] & ~sclk_prev_q;
    assign fs_s = pin_s2_q[LP_PIN_FS];
    assign sd_s = pin_s2_q[LP_PIN_SD];
    assign byp_n = pin_s2_q[LP_PIN_BYP_N];
    assign frst_n = pin_s2_q[LP_PIN_FRST_N];
    assign mute_n = pin_s2_q[LP_PIN_MUTE_N];
    assign rate_pins = {pin_s2_q[LP_PIN_RATE_HI], pin_s2_q[LP_PIN_RATE_LO]};

    // ----------------------------------------------------------------
    // Framing and output state
    // ----------------------------------------------------------------
    logic [15:0] sreg_q, sreg_d, hold_q, hold_d, dac_q, dac_d;
    logic fs_prev_q, fs_prev_d, first_q, first_d;
    logic stb_q, stb_d, err_q, err_d;
    logic [3:0] ph_q, ph_d, step_mask;
    logic [4:0] cnt_q, cnt_d;
    logic [1:0] rate_q, rate_d;
    logic boundary, bad_frame, word_ev, f_load, f_tick, f_clr;
    logic [15:0] f_y;

    always_comb begin
        sreg_d = sreg_q;
        hold_d = hold_q;
        dac_d = dac_q;
        fs_prev_d = fs_prev_q;
        first_d = first_q;
        ph_d = ph_q;
        cnt_d = cnt_q;
        rate_d = rate_q;
        stb_d = 1'b0;
        err_d = 1'b0;

        // Falling frame sync seen at a bit clock rise
        boundary = sclk_rise & fs_prev_q & ~fs_s;
        bad_frame = boundary & ~first_q & (cnt_q != LP_FRAME_BITS);
        // Third rise after the frame sync fall: 2.5 bit clocks
        word_ev = sclk_rise & (ph_q == LP_PH_LOAD);
        step_mask = LP_PH_MASK >> ({1'b0, rate_q} + 3'h1);
        // One new word per frame enters the filter
        f_load = word_ev;
        f_tick = sclk_rise & (((ph_q - LP_PH_LOAD) & step_mask) == 4'h0);
        // Pin reset clears filter, not the serial input
        f_clr = ~frst_n | bad_frame;

        if (sclk_rise) begin
            // MSB first, last 16 bits kept
            sreg_d = {sreg_q[14:0], sd_s};
            fs_prev_d = fs_s;
            if (boundary) begin
                hold_d = sreg_q;
                ph_d = 4'h0;
                cnt_d = 5'h01;
                first_d = 1'b0;
            end else begin
                ph_d = ph_q + 4'h1;
                if (cnt_q != LP_CNT_MAX) begin
                    cnt_d = cnt_q + 5'h01;
                end
            end
        end

        // Release frame may hold any count
        if (!frst_n) begin
            first_d = 1'b1;
        end

        // Rate taken only while filter is in reset
        if (f_clr) begin
            rate_d = rate_pins;
        end

        if (bad_frame) begin
            err_d = 1'b1;
        end

        // Mute outranks every other mode
        if (!mute_n) begin
            if (word_ev) begin
                dac_d = LP_MID_SCALE;
                stb_d = 1'b1;
            end
        end else if (!byp_n) begin
            if (word_ev) begin
                dac_d = hold_q;
                stb_d = 1'b1;
            end
        end else if (!frst_n) begin
            // Mid-scale on each bit clock rise
            if (sclk_rise) begin
                dac_d = LP_MID_SCALE;
                stb_d = 1'b1;
            end
        end else begin
            // Filtered words at N per frame
            if (f_tick) begin
                dac_d = f_y;
                stb_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sreg_q <= LP_MID_SCALE;
            hold_q <= LP_MID_SCALE;
            dac_q <= LP_MID_SCALE;
            fs_prev_q <= 1'b0;
            first_q <= 1'b1;
            ph_q <= LP_PH_RST;
            cnt_q <= 5'h00;
            rate_q <= LP_RATE_RST;
            stb_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            sreg_q <= sreg_d;
            hold_q <= hold_d;
            dac_q <= dac_d;
            fs_prev_q <= fs_prev_d;
            first_q <= first_d;
            ph_q <= ph_d;
            cnt_q <= cnt_d;
            rate_q <= rate_d;
            stb_q <= stb_d;
            err_q <= err_d;
        end
    end

    // ----------------------------------------------------------------
    // Interpolator
    // ----------------------------------------------------------------
    // Comb cascade, history at code zero
    cicif_core #(
        .W(LP_ACC_W)
    ) u_core (
        .clk(clk),
        .rst_b(rst_b),
        .clr(f_clr),
        .load(f_load),
        .tick(f_tick),
        .rate(rate_q),
        .x_in(hold_q),
        .y_out(f_y)
    );

    assign dac_word = dac_q;
    assign dac_strobe = stb_q;
    assign frame_error = err_q;

endmodule // cicif_dev

`default_nettype wire

// ---- cicif_host.sv ----
/*
 * Host end: an Avalon-MM slave with control, data and status registers,
 * and a serial word transmitter that makes the bit clock by division.
 * Assumes software writes one word per frame through the data register.
 */
`default_nettype none

module cicif_host
    import cicif_pkg::*;
#(
    parameter int unsigned HALF_CYC = LP_SCLK_HALF_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    cicif_link_if.host link
);

    // Divider keeps the bit clock sampled and within rate
    if (HALF_CYC < LP_SCLK_HALF_MIN || HALF_CYC > 256) begin : g_bad_div
        $error("cicif_host: bit clock half period out of range");
    end

    localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);

    cicif_bus_t bus_q, bus_d;
    logic [LP_CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [31:0] rdata_q, rdata_d;
    logic [15:0] slot_q, slot_d, tx_q, tx_d, word;
    logic full_q, full_d, sclk_q, sclk_d, fs_q, fs_d, sd_q, sd_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] div_q, div_d;
    logic data_wr, pop, wait_q, wait_d;

    always_comb begin
        bus_d = bus_q;
        ctrl_d = ctrl_q;
        rdata_d = rdata_q;
        slot_d = slot_q;
        tx_d = tx_q;
        sclk_d = sclk_q;
        fs_d = fs_q;
        sd_d = sd_q;
        bit_d = bit_q;
        div_d = div_q;
        data_wr = 1'b0;
        pop = 1'b0;
        word = tx_q;

        // ------------------------------------------------------------
        // Bus slave: one wait cycle; data writes stall while slot full
        // ------------------------------------------------------------
        case (bus_q)
            BUS_IDLE: begin
                if ((avs_read || avs_write)
                    && !(avs_write && avs_address == LP_OFS_DATA && full_q)) begin
                    bus_d = BUS_ACK;
                    case (avs_address)
                        LP_OFS_CTRL: rdata_d = {26'h000_0000, ctrl_q};
                        LP_OFS_DATA: rdata_d = {16'h0000, slot_q};
                        LP_OFS_STAT: rdata_d = {30'h0000_0000, ctrl_q[LP_CB_RUN], full_q};
                        default: rdata_d = LP_RDATA_RST;
                    endcase
                end
            end
            BUS_ACK: begin
                bus_d = BUS_IDLE;
                if (avs_write && avs_address == LP_OFS_CTRL) begin
                    ctrl_d = avs_writedata[LP_CTRL_W-1:0];
                end
                if (avs_write && avs_address == LP_OFS_DATA) begin
                    slot_d = avs_writedata[15:0];
                    data_wr = 1'b1;
                end
            end
            default: bus_d = BUS_IDLE;
        endcase

        // ------------------------------------------------------------
        // Transmitter: changes pins on bit clock falling edges
        // ------------------------------------------------------------
        if (!ctrl_q[LP_CB_RUN]) begin
            sclk_d = 1'b0;
            div_d = 8'h00;
            bit_d = LP_BIT_IDLE;
            fs_d = 1'b1;
        end else if (div_q == HALF_M1) begin
            div_d = 8'h00;
            sclk_d = ~sclk_q;
            if (sclk_q) begin
                // Exactly 16 bit clocks per frame
                bit_d = bit_q + 4'h1;
                if (bit_d == 4'h0) begin
                    pop = full_q;
                    word = full_q ? slot_q : tx_q;
                    tx_d = word;
                end
                // Word sent MSB first, as written
                sd_d = word[4'hf - bit_d];
                fs_d = (bit_d >= LP_WORD_FRAME_SYNC_HIGH_BIT);
            end
        end else begin
            div_d = div_q + 8'h01;
        end

        full_d = (full_q & ~pop) | data_wr;
        // Registered so the bus sees waitrequest straight from a flop
        wait_d = (bus_d != BUS_ACK);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_q <= BUS_IDLE;
            ctrl_q <= LP_CTRL_RST;
            rdata_q <= LP_RDATA_RST;
            slot_q <= LP_MID_SCALE;
            tx_q <= LP_MID_SCALE;
            full_q <= 1'b0;
            sclk_q <= 1'b0;
            fs_q <= 1'b1;
            sd_q <= 1'b0;
            bit_q <= LP_BIT_IDLE;
            div_q <= 8'h00;
            wait_q <= 1'b1;
        end else begin
            bus_q <= bus_d;
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
            slot_q <= slot_d;
            tx_q <= tx_d;
            full_q <= full_d;
            sclk_q <= sclk_d;
            fs_q <= fs_d;
            sd_q <= sd_d;
            bit_q <= bit_d;
            div_q <= div_d;
            wait_q <= wait_d;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign link.sclk = sclk_q;
    assign link.word_frame_sync = fs_q;
    assign link.serial_data_in = sd_q;
    assign link.filter_bypass_n = ctrl_q[LP_CB_BYP_N];
    assign link.filter_reset_n = ctrl_q[LP_CB_FRST_N];
    assign link.rate_select_lo = ctrl_q[LP_CB_RATE_LO];
    assign link.rate_select_hi = ctrl_q[LP_CB_RATE_HI];
    assign link.output_mute_n = ctrl_q[LP_CB_MUTE_N];

endmodule // cicif_host

`default_nettype wire

// ---- cicif_link_if.sv ----
/*
 * Serial word link between the host and the interpolating device.
 * All signals are plain levels driven by the host end only.
 */
`default_nettype none

interface cicif_link_if;
    logic sclk;
    logic word_frame_sync;
    logic serial_data_in;
    logic filter_bypass_n;
    logic filter_reset_n;
    logic rate_select_hi;
    logic rate_select_lo;
    logic output_mute_n;

    modport host (
        output sclk,
        output word_frame_sync,
        output serial_data_in,
        output filter_bypass_n,
        output filter_reset_n,
        output rate_select_hi,
        output rate_select_lo,
        output output_mute_n
    );

    modport dev (
        input sclk,
        input word_frame_sync,
        input serial_data_in,
        input filter_bypass_n,
        input filter_reset_n,
        input rate_select_hi,
        input rate_select_lo,
        input output_mute_n
    );
endinterface

`default_nettype wire

// ---- cicif_monitor.sv ----
/*
 * Checker for the serial word link and the converter latch outputs.
 * Assumes one clk domain and a host bit clock half period of four clk cycles.
 */
`default_nettype none

module cicif_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic word_frame_sync,
    input wire logic filter_bypass_n,
    input wire logic filter_reset_n,
    input wire logic output_mute_n,
    input wire logic [15:0] dac_word,
    input wire logic dac_strobe,
    input wire logic frame_error
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Cycles since the last latch update, saturating
    // ------------------------------------------------------------
    logic [7:0] gap_q;
    logic [7:0] gap_d;

    always_comb begin
        gap_d = (gap_q == 8'hff) ? gap_q : gap_q + 8'h01;
        if (dac_strobe) begin
            gap_d = 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gap_q <= 8'hff;
        end else begin
            gap_q <= gap_d;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_sclk_even;
        $rose(sclk) |-> sclk [*4] ##1 !sclk;
    endproperty
    property p_frame_len;
        $fell(word_frame_sync) |-> ##64 $rose(word_frame_sync) ##64 $fell(word_frame_sync);
    endproperty
    // at most one update per bit
    property p_strobe_gap;
        dac_strobe |=> !dac_strobe [*7];
    endproperty
    property p_mute_mid;
        dac_strobe && !output_mute_n && !$past(output_mute_n, 16) |-> dac_word == 16'h0000;
    endproperty
    property p_frst_mid;
        dac_strobe && output_mute_n && filter_bypass_n && !filter_reset_n
            && !$past(filter_reset_n, 16) |-> dac_word == 16'h0000;
    endproperty
    property p_raw_gap;
        dac_strobe && !filter_bypass_n && !$past(filter_bypass_n, 140)
            && !$past(filter_bypass_n, 70) |-> gap_q == 8'h7f;
    endproperty
    property p_raw_update;
        $fell(word_frame_sync) && !filter_bypass_n && output_mute_n |-> ##[8:40] dac_strobe;
    endproperty
    property p_no_ferr;
        filter_reset_n && $past(filter_reset_n, 300) |-> !frame_error;
    endproperty

    a_sclk_even: assert property (p_sclk_even) else $error("bit clock uneven");
    a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
    a_strobe_gap: assert property (p_strobe_gap) else $error("updates too close");
    a_mute_mid: assert property (p_mute_mid) else $error("muted word not zero");
    a_frst_mid: assert property (p_frst_mid) else $error("reset word not zero");
    a_raw_gap: assert property (p_raw_gap) else $error("bypass update spacing");
    a_raw_update: assert property (p_raw_update) else $error("raw update missing");
    a_no_ferr: assert property (p_no_ferr) else $error("spurious frame error");

    c_strobe: cover property (dac_strobe && dac_word != 16'h0000);
    c_muted: cover property (dac_strobe && !output_mute_n);
    c_frame: cover property ($fell(word_frame_sync));
endmodule // cicif_monitor

`default_nettype wire

// ---- cicif_pkg.sv ----
/*
 * Shared constants for the comb interpolation filter link: word and frame
 * sizes, reset values, host register map and link timing.
 * Assumes a 50 MHz system clock on both ends of the link.
 */
`default_nettype none

package cicif_pkg;

    // ----------------------------------------------------------------
    // Word, frame and arithmetic sizes
    // ----------------------------------------------------------------
    localparam int unsigned LP_WORD_W = 16;
    localparam logic [4:0] LP_FRAME_BITS = 5'h10;
    localparam logic [4:0] LP_CNT_MAX = 5'h1f;
    localparam logic [15:0] LP_MID_SCALE = 16'h0000;
    localparam int unsigned LP_ACC_W = 32;
    localparam int unsigned LP_ACC_MIN_W = 30;

    // ----------------------------------------------------------------
    // Frame phases and reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] LP_PH_LOAD = 4'h1;
    localparam logic [3:0] LP_PH_RST = 4'h2;
    localparam logic [3:0] LP_PH_MASK = 4'hf;
    localparam logic [3:0] LP_WORD_FRAME_SYNC_HIGH_BIT = 4'h8;
    localparam logic [3:0] LP_BIT_IDLE = 4'hf;
    localparam logic [1:0] LP_RATE_RST = 2'h0;

    // ----------------------------------------------------------------
    // Link timing
    // ----------------------------------------------------------------
    localparam int unsigned LP_CLK_PERIOD_NS = 20;
    localparam int unsigned LP_SCLK_PERIOD_NS = 160;
    localparam int unsigned LP_SCLK_HALF_CYC = LP_SCLK_PERIOD_NS / (2 * LP_CLK_PERIOD_NS);
    localparam int unsigned LP_SCLK_HALF_MIN = 2;

    // ----------------------------------------------------------------
    // Host register map (byte addresses) and fields
    // ----------------------------------------------------------------
    localparam logic [3:0] LP_OFS_CTRL = 4'h0;
    localparam logic [3:0] LP_OFS_DATA = 4'h4;
    localparam logic [3:0] LP_OFS_STAT = 4'h8;
    localparam int unsigned LP_CTRL_W = 6;
    localparam logic [5:0] LP_CTRL_RST = 6'h00;
    localparam int unsigned LP_CB_RUN = 0;
    localparam int unsigned LP_CB_BYP_N = 1;
    localparam int unsigned LP_CB_FRST_N = 2;
    localparam int unsigned LP_CB_RATE_LO = 3;
    localparam int unsigned LP_CB_RATE_HI = 4;
    localparam int unsigned LP_CB_MUTE_N = 5;
    localparam logic [31:0] LP_RDATA_RST = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Device pin sampling vector positions
    // ----------------------------------------------------------------
    localparam int unsigned LP_PIN_N = 8;
    localparam int unsigned LP_PIN_SCLK = 0;
    localparam int unsigned LP_PIN_FS = 1;
    localparam int unsigned LP_PIN_SD = 2;
    localparam int unsigned LP_PIN_BYP_N = 3;
    localparam int unsigned LP_PIN_FRST_N = 4;
    localparam int unsigned LP_PIN_RATE_LO = 5;
    localparam int unsigned LP_PIN_RATE_HI = 6;
    localparam int unsigned LP_PIN_MUTE_N = 7;

    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } cicif_bus_t;

endpackage

`default_nettype wire

// ---- tb.sv ----
/*
 * Testbench joining host and device ends over the serial word link.
 * Assumes the host answers over Avalon-MM and repeats its last word each frame.
 */
`default_nettype none

`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin num_errors++; $display("wrong value %s exp %h seen %h", n, e, s); end end

module tb
    import cicif_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {logic [31:0] ctrl; logic [15:0] word; logic [15:0] exp; int nstb;} cicif_row_t;
    logic clk, rst_b, avs_read, avs_write, avs_waitrequest, dac_strobe, frame_error;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [15:0] dac_word;
    int num_errors, n_checks, nstb, nferr;
    cicif_row_t rows [8];

    cicif_link_if link();
    cicif_host #(.HALF_CYC(4)) i_cicif_host (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link));
    cicif_dev i_cicif_dev (.clk(clk), .rst_b(rst_b), .link(link), .dac_word(dac_word),
        .dac_strobe(dac_strobe), .frame_error(frame_error));
    cicif_monitor i_cicif_monitor (.clk(clk), .rst_b(rst_b), .sclk(link.sclk),
        .word_frame_sync(link.word_frame_sync), .filter_bypass_n(link.filter_bypass_n),
        .filter_reset_n(link.filter_reset_n), .output_mute_n(link.output_mute_n),
        .dac_word(dac_word), .dac_strobe(dac_strobe), .frame_error(frame_error));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Bus master and closing
    // ------------------------------------------------------------
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task test_done;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        test_done();
    end

    initial begin
        {rst_b, avs_read, avs_write, avs_address, avs_writedata} = '0;
        // Filtered rows first so the bypass spacing check always has a prior update
        rows[0] = '{32'h0000_0027, 16'h7fff, 16'h7fff, 8};
        rows[1] = '{32'h0000_002f, 16'h8000, 16'h8000, 16};
        rows[2] = '{32'h0000_0037, 16'hc35a, 16'hc35a, 32};
        rows[3] = '{32'h0000_003f, 16'h0001, 16'h0001, 64};
        rows[4] = '{32'h0000_0023, 16'h5555, 16'h0000, 64};
        rows[5] = '{32'h0000_0025, 16'ha5a5, 16'ha5a5, 4};
        rows[6] = '{32'h0000_0021, 16'h2468, 16'h2468, 4};
        rows[7] = '{32'h0000_0007, 16'h4000, 16'h0000, 4};
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        bus(1'b1, LP_OFS_DATA, 32'h0000_1357);
        bus(1'b0, LP_OFS_DATA, 32'h0000_0000);
        `CHK("data readback", 16'h1357, rd[15:0])
        // ------------------------------------------------------------
        // Mode and rate table
        // ------------------------------------------------------------
        foreach (rows[i]) begin
            bus(1'b1, LP_OFS_CTRL, rows[i].ctrl & 32'hffff_fffb);
            bus(1'b1, LP_OFS_CTRL, rows[i].ctrl);
            bus(1'b1, LP_OFS_DATA, {16'h0000, rows[i].word});
            repeat (1024) @(posedge clk);
            nstb = 0;
            for (int k = 0; k < 512; k++) begin
                @(posedge clk);
                if (dac_strobe === 1'b1) nstb++;
                if (frame_error !== 1'b0) nferr++;
            end
            `CHK("update count", rows[i].nstb, nstb)
            `CHK("latch word", rows[i].exp, dac_word)
        end
        // Every frame held 16 bit clocks, so no automatic filter reset may appear
        `CHK("frame error count", 0, nferr)
        bus(1'b0, 4'hc, 32'h0000_0000);
        `CHK("unmapped read", 32'h0000_0000, rd)
        bus(1'b0, LP_OFS_STAT, 32'h0000_0000);
        `CHK("run status", 1'b1, rd[1])
        // ------------------------------------------------------------
        // Reset in mid-run
        // ------------------------------------------------------------
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("reset word", 16'h0000, dac_word)
        `CHK("reset bit clock", 1'b0, link.sclk)
        `CHK("reset frame sync", 1'b1, link.word_frame_sync)
        `CHK("reset wait", 1'b1, avs_waitrequest)
        rst_b <= 1'b1;
        bus(1'b0, LP_OFS_CTRL, 32'h0000_0000);
        `CHK("ctrl reset", 32'h0000_0000, rd)
        test_done();
    end
endmodule // tb

`default_nettype wire
